// [pwmdpc_pkg.sv]
package pwmdpc_pkg;
    localparam int DATA_W = 16;

    // register byte addresses
    localparam logic [4:0] ADDR_DUTY   = 5'h00;
    localparam logic [4:0] ADDR_PHASE  = 5'h04;
    localparam logic [4:0] ADDR_FLCTL  = 5'h08;
    localparam logic [4:0] ADDR_GENCTL = 5'h0C;
    localparam logic [4:0] ADDR_OUTCTL = 5'h10;
    localparam logic [4:0] ADDR_UNLOCK = 5'h14;
    localparam logic [4:0] ADDR_STATUS = 5'h18;

    // reset values
    localparam logic [15:0] DUTY_RST   = 16'h0000;
    localparam logic [15:0] PHASE_RST  = 16'h0000;
    localparam logic [15:0] FLCTL_RST  = 16'h00F8;
    localparam logic [15:0] GENCTL_RST = 16'h0000;
    localparam logic [15:0] OUTCTL_RST = 16'h0000;

    // fault_limit_control fields
    localparam int LSRC_HI  = 14;
    localparam int LSRC_LO  = 10;
    localparam int LPOL_BIT = 9;
    localparam int LMOD_BIT = 8;
    localparam logic [15:0] FLCTL_MASK = 16'h7FFF;

    // generator_control_reg fields
    localparam int GEN_EN_BIT = 0;
    localparam int ITB_BIT    = 9;
    localparam logic [15:0] GENCTL_MASK = 16'h0201;

    // output_control_reg fields
    localparam int OUTPUT_PAIR_MODE_HI = 11;
    localparam int OUTPUT_PAIR_MODE_LO = 10;
    localparam logic [15:0] OUTCTL_MASK = 16'h0C00;

    // unlock keys, written back to back
    localparam logic [15:0] UNLOCK_KEY1 = 16'hABCD;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h4321;

    // limit source codes and input vector positions
    localparam logic [4:0] LSRC_FLT1  = 5'h00;
    localparam logic [4:0] LSRC_FLT4  = 5'h03;
    localparam logic [4:0] LSRC_CMP1  = 5'h08;
    localparam logic [4:0] LSRC_CMP4  = 5'h0B;
    localparam logic [4:0] LSRC_FLT32 = 5'h1F;
    localparam int LIM_N       = 9;
    localparam int LIM_CMP_POS = 4;
    localparam int LIM_F32_POS = 8;

    typedef enum logic [1:0] {
        OUTPUT_PAIR_MODE_COMPL,
        OUTPUT_PAIR_MODE_REDUND,
        OUTPUT_PAIR_MODE_PUSHPULL,
        OUTPUT_PAIR_MODE_INDEP
    } pwmdpc_output_pair_mode_type;
endpackage : pwmdpc_pkg

// [pwmdpc_timebase.sv]
`timescale 1ns/1ps
`default_nettype none
module pwmdpc_timebase
    import pwmdpc_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // control
    input  wire logic              run,
    input  wire logic [DATA_W-1:0] period,
    // count
    output var  logic [DATA_W-1:0] count_q,
    output var  logic              wrap_q
);
    // local time base counts 0..period inclusive
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            wrap_q  <= 1'b0;
        end else if (!run) begin
            count_q <= '0;
            wrap_q  <= 1'b0;
        end else if (count_q >= period) begin
            count_q <= '0;
            wrap_q  <= 1'b1;
        end else begin
            count_q <= count_q + 16'h0001;
            wrap_q  <= 1'b0;
        end
    end
endmodule : pwmdpc_timebase
`default_nettype wire

// [pwmdpc_core.sv]
`timescale 1ns/1ps
`default_nettype none
module pwmdpc_core
    import pwmdpc_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // avalon-mm slave
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output var  logic [31:0]       avs_readdata,
    output var  logic              avs_waitrequest,
    // time base and limit inputs
    input  wire logic [DATA_W-1:0] master_count,
    input  wire logic [LIM_N-1:0]  limit_in,
    input  wire logic              write_lock_fuse,
    // power stage
    output var  logic              high_side_output,
    output var  logic              low_side_output
);
    logic [1:0]        rst_sync_q;
    logic              rst_n;
    logic [LIM_N-1:0]  lim_s1_q, lim_s2_q;
    logic              fuse_s1_q, fuse_s2_q, fuse_q;
    logic [2:0]        fuse_done_q;
    logic [15:0]       duty_q, phase_q, flctl_q, genctl_q, outctl_q;
    logic              wait_q;
    logic [31:0]       rdata_q;
    logic              key1_seen_q, unlocked_q;
    logic              high_q, low_q, pp_sel_q;
    logic              wr_acc, rd_acc, outctl_wr_ok;
    logic              gen_en, independent_timebase_select;
    pwmdpc_output_pair_mode_type   output_pair_mode;
    logic [DATA_W-1:0] loc_count, tb_count;
    logic              loc_wrap, tb_wrap, raw_active;
    logic              lim_pick, limit_active;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
        merge16[7:0]  = be[0] ? new_v[7:0]  : old_v[7:0];
        merge16[15:8] = be[1] ? new_v[15:8] : old_v[15:8];
    endfunction : merge16

    function automatic logic pick_limit(input logic [4:0]       src,
                                        input logic [LIM_N-1:0] v);
        pick_limit = 1'b0;
        if (src <= LSRC_FLT4) begin
            pick_limit = v[src[1:0]];
        end else if (src >= LSRC_CMP1 && src <= LSRC_CMP4) begin
            pick_limit = v[LIM_CMP_POS + int'(src[1:0])];
        end else if (src == LSRC_FLT32) begin
            pick_limit = v[LIM_F32_POS];
        end
    endfunction : pick_limit

    // reset release synchroniser
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // pin synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lim_s1_q  <= '0;
            lim_s2_q  <= '0;
            fuse_s1_q <= 1'b0;
            fuse_s2_q <= 1'b0;
        end else begin
            lim_s1_q  <= limit_in;
            lim_s2_q  <= lim_s1_q;
            fuse_s1_q <= write_lock_fuse;
            fuse_s2_q <= fuse_s1_q;
        end
    end

    // fuse sampled until the pin synchroniser holds a real sample, then frozen
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fuse_q      <= 1'b0;
            fuse_done_q <= 3'h0;
        end else if (!fuse_done_q[2]) begin
            fuse_q      <= fuse_s2_q;
            fuse_done_q <= {fuse_done_q[1:0], 1'b1};
        end
    end

    // bus handshake: one wait cycle, then the access completes
    assign wr_acc = avs_write && !wait_q;
    assign rd_acc = avs_read && !wait_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (avs_read && wait_q) begin
            if (avs_address == ADDR_DUTY) begin
                rdata_q <= {16'h0000, duty_q};
            end else if (avs_address == ADDR_PHASE) begin
                rdata_q <= {16'h0000, phase_q};
            end else if (avs_address == ADDR_FLCTL) begin
                rdata_q <= {16'h0000, flctl_q};
            end else if (avs_address == ADDR_GENCTL) begin
                rdata_q <= {16'h0000, genctl_q};
            end else if (avs_address == ADDR_OUTCTL) begin
                rdata_q <= {16'h0000, outctl_q};
            end else if (avs_address == ADDR_STATUS) begin
                rdata_q <= {11'h000, unlocked_q, fuse_q, limit_active, low_q, high_q, tb_count};
            end else begin
                rdata_q <= '0;
            end
        end
    end
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    // register writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            duty_q <= DUTY_RST;
        end else if (wr_acc && avs_address == ADDR_DUTY) begin
            duty_q <= merge16(duty_q, avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PHASE_RST;
        end else if (wr_acc && avs_address == ADDR_PHASE) begin
            phase_q <= merge16(phase_q, avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flctl_q <= FLCTL_RST;
        end else if (wr_acc && avs_address == ADDR_FLCTL) begin
            flctl_q <= merge16(flctl_q, avs_writedata, avs_byteenable) & FLCTL_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            genctl_q <= GENCTL_RST;
        end else if (wr_acc && avs_address == ADDR_GENCTL) begin
            genctl_q <= merge16(genctl_q, avs_writedata, avs_byteenable) & GENCTL_MASK;
        end
    end

    // output control guarded by the lock fuse
    assign outctl_wr_ok = wr_acc && avs_address == ADDR_OUTCTL && (!fuse_q || unlocked_q);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            outctl_q <= OUTCTL_RST;
        end else if (outctl_wr_ok) begin
            outctl_q <= merge16(outctl_q, avs_writedata, avs_byteenable) & OUTCTL_MASK;
        end
    end

    // unlock: two keys back to back open one output control write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            key1_seen_q <= 1'b0;
            unlocked_q  <= 1'b0;
        end else if (wr_acc) begin
            if (avs_address == ADDR_UNLOCK && avs_writedata[15:0] == UNLOCK_KEY1) begin
                key1_seen_q <= 1'b1;
                unlocked_q  <= 1'b0;
            end else if (avs_address == ADDR_UNLOCK && key1_seen_q
                         && avs_writedata[15:0] == UNLOCK_KEY2) begin
                key1_seen_q <= 1'b0;
                unlocked_q  <= 1'b1;
            end else begin
                key1_seen_q <= 1'b0;
                unlocked_q  <= unlocked_q && avs_address != ADDR_OUTCTL;
            end
        end
    end

    // time base selection
    assign gen_en = genctl_q[GEN_EN_BIT];
    assign independent_timebase_select    = genctl_q[ITB_BIT];
    assign output_pair_mode   = pwmdpc_output_pair_mode_type'(outctl_q[OUTPUT_PAIR_MODE_HI:OUTPUT_PAIR_MODE_LO]);

    pwmdpc_timebase u_timebase (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .run     (gen_en && independent_timebase_select),
        .period  (phase_q),
        .count_q (loc_count),
        .wrap_q  (loc_wrap)
    );

    assign tb_count   = independent_timebase_select ? loc_count : master_count - phase_q;
    assign tb_wrap    = independent_timebase_select ? loc_wrap : (tb_count == '0);
    assign raw_active = tb_count < duty_q;

    // current limit
    assign lim_pick     = pick_limit(flctl_q[LSRC_HI:LSRC_LO], lim_s2_q);
    assign limit_active = flctl_q[LMOD_BIT] && (lim_pick ^ flctl_q[LPOL_BIT]);

    // output stage; an active limit forces both sides off
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pp_sel_q <= 1'b0;
        end else if (gen_en && tb_wrap) begin
            pp_sel_q <= !pp_sel_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            high_q <= 1'b0;
            low_q  <= 1'b0;
        end else if (!gen_en || limit_active) begin
            high_q <= 1'b0;
            low_q  <= 1'b0;
        end else begin
            case (output_pair_mode)
                OUTPUT_PAIR_MODE_COMPL: begin
                    high_q <= raw_active;
                    low_q  <= !raw_active;
                end
                OUTPUT_PAIR_MODE_PUSHPULL: begin
                    high_q <= raw_active && !pp_sel_q;
                    low_q  <= raw_active && pp_sel_q;
                end
                default: begin
                    high_q <= raw_active;
                    low_q  <= raw_active;
                end
            endcase
        end
    end
    assign high_side_output = high_q;
    assign low_side_output  = low_q;

    a_duty_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_acc && avs_address == ADDR_DUTY && avs_byteenable == 4'hF
        |=> duty_q == $past(avs_writedata[15:0]))
        else $error("duty write not stored");
    a_phase_shift_use: assert property (@(posedge mclk) disable iff (!rst_n)
        gen_en && !independent_timebase_select && !limit_active && output_pair_mode == OUTPUT_PAIR_MODE_COMPL
        |=> high_q == (16'($past(master_count) - $past(phase_q)) < $past(duty_q)))
        else $error("phase shift not applied");
    a_itb_period_bound: assert property (@(posedge mclk) disable iff (!rst_n)
        gen_en && independent_timebase_select && loc_count == phase_q |=> loc_count == '0)
        else $error("local time base did not wrap at period");
    a_limit_source_f32: assert property (@(posedge mclk) disable iff (!rst_n)
        flctl_q[LSRC_HI:LSRC_LO] == LSRC_FLT32 |-> lim_pick == lim_s2_q[LIM_F32_POS])
        else $error("fault 32 source not selected");

    a_limit_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
        flctl_q[LMOD_BIT] |-> limit_active == (lim_pick != flctl_q[LPOL_BIT]))
        else $error("limit polarity wrong");
    a_limit_off_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        limit_active |=> !high_q && !low_q)
        else $error("outputs active under current limit");
    a_lock_blocks_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_acc && avs_address == ADDR_OUTCTL && fuse_q && !unlocked_q |=> $stable(outctl_q))
        else $error("locked output control was written");

    a_duty_compare: assert property (@(posedge mclk) disable iff (!rst_n)
        gen_en && !limit_active && output_pair_mode == OUTPUT_PAIR_MODE_COMPL
        |=> high_q == $past(raw_active) && low_q != high_q)
        else $error("complementary output does not follow duty compare");

    a_bus_one_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
        else $error("waitrequest not a single cycle low");
endmodule : pwmdpc_core
`default_nettype wire

// [pwmdpc_stage.sv]
`timescale 1ns/1ps
`default_nettype none
module pwmdpc_stage (
    // clock
    input  wire logic mclk,
    // gate drives
    input  wire logic high_side_output,
    input  wire logic low_side_output,
    // half-bridge state
    output var  logic node_q,
    output var  logic short_q
);
    // with both gates off the node floats, so it is shown toggling
    always_ff @(posedge mclk) begin
        if (high_side_output && !low_side_output) begin
            node_q <= 1'b1;
        end else if (low_side_output && !high_side_output) begin
            node_q <= 1'b0;
        end else if (!high_side_output) begin
            node_q <= ~node_q;
        end
        short_q <= high_side_output & low_side_output;
    end
endmodule : pwmdpc_stage
`default_nettype wire

// [pwm_duty_phase_current_limit_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_phase_current_limit_tb_top
    import pwmdpc_pkg::*;
;
    logic        mclk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rs, q;
    logic [3:0]  avs_byteenable;
    logic [15:0] master_count;
    logic [8:0]  limit_in;
    logic        write_lock_fuse, high_side_output, low_side_output, k1, unl;
    logic [15:0] m_reg [8];
    int          mismatches, checked;

    pwmdpc_core i_dut (.mclk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .master_count, .limit_in,
        .write_lock_fuse, .high_side_output, .low_side_output);
    pwmdpc_stage i_stage (.mclk, .high_side_output, .low_side_output, .node_q(), .short_q());

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd

    function automatic logic [15:0] mask(input logic [4:0] a);
        case (a)
            ADDR_DUTY, ADDR_PHASE: return 16'hFFFF;
            ADDR_FLCTL:            return FLCTL_MASK;
            ADDR_GENCTL:           return GENCTL_MASK;
            ADDR_OUTCTL:           return OUTCTL_MASK;
            default:               return 16'h0000;
        endcase
    endfunction : mask

    function automatic int lpos(input logic [4:0] c);
        if (c <= 5'h03) return int'(c);
        if (c >= 5'h08 && c <= 5'h0B) return int'(c) - 4;
        if (c == 5'h1F) return 8;
        return -1;
    endfunction : lpos

    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk_reg

    task automatic chk_pin(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask : chk_pin

    task automatic model_wr(input logic [4:0] a, input logic [15:0] d, input logic [3:0] be);
        logic [15:0] v;
        v = m_reg[a[4:2]];
        if (be[0]) v[7:0] = d[7:0];
        if (be[1]) v[15:8] = d[15:8];
        if (a == ADDR_UNLOCK) begin
            unl = (d != UNLOCK_KEY1) && (unl || (k1 && d == UNLOCK_KEY2));
            k1 = (d == UNLOCK_KEY1);
        end else begin
            k1 = 1'b0;
            if (a != ADDR_OUTCTL || unl) m_reg[a[4:2]] = v & mask(a);
            if (a == ADDR_OUTCTL) unl = 1'b0;
        end
    endtask : model_wr

    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= {16'h0000, d};
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        chk_reg("bus latency", 32'h2, 32'(n));
        if (wr) model_wr(a, d, be);
    endtask : bus

    task automatic rd(input logic [4:0] a);
        bus(1'b0, a, 16'h0000, 4'hF);
        chk_reg("register", {16'h0000, m_reg[a[4:2]]}, q);
    endtask : rd

    task automatic set_out(input logic [1:0] m);
        bus(1'b1, ADDR_UNLOCK, UNLOCK_KEY1, 4'hF);
        bus(1'b1, ADDR_UNLOCK, UNLOCK_KEY2, 4'hF);
        bus(1'b1, ADDR_OUTCTL, {4'h0, m, 10'h000}, 4'hF);
    endtask : set_out

    task automatic pwm_chk();
        logic [15:0] c;
        logic        a;
        logic [1:0]  md;
        c = 16'(rnd());
        @(posedge mclk);
        master_count <= c;
        @(posedge mclk);
        @(negedge mclk);
        a = (16'(c - m_reg[1]) < m_reg[0]);
        md = m_reg[4][11:10];
        if (md == 2'b10) begin
            chk_pin("steered pair", a, high_side_output | low_side_output);
            chk_pin("pair overlap", 1'b0, high_side_output & low_side_output);
        end else begin
            chk_pin("high side", a, high_side_output);
            chk_pin("low side", (md == 2'b00) ? !a : a, low_side_output);
        end
    endtask : pwm_chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    initial begin
        repeat (30000) @(posedge mclk);
        mismatches++;
        stop_test();
    end

    initial begin
        logic [4:0] codes [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0A, 5'h0B,
                                   5'h1F, 5'h04, 5'h1E};
        logic       pol, sel;
        logic [8:0] lim;
        int         hc, p;
        rs = 32'd26;
        mismatches = 0;
        checked = 0;
        k1 = 1'b0;
        unl = 1'b0;
        foreach (m_reg[i]) m_reg[i] = 16'h0000;
        m_reg[2] = 16'h00F8;
        rstn = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        master_count = 16'h0000;
        limit_in = 9'h000;
        write_lock_fuse = 1'b1;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 5; i++) rd(5'(i * 4));
        rd(5'h1C);
        bus(1'b1, ADDR_OUTCTL, 16'h0C00, 4'hF);
        rd(ADDR_OUTCTL);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 5'(i * 4), 16'(rnd()), 4'hF);
            rd(5'(i * 4));
        end
        bus(1'b1, ADDR_DUTY, 16'(rnd()), 4'h2);
        rd(ADDR_DUTY);
        bus(1'b1, ADDR_FLCTL, 16'h0000, 4'hF);
        bus(1'b1, ADDR_GENCTL, 16'h0001, 4'hF);
        for (int m = 0; m < 4; m++) begin
            set_out(2'(m));
            rd(ADDR_OUTCTL);
            for (int j = 0; j < 6; j++) begin
                bus(1'b1, ADDR_DUTY, 16'(rnd()), 4'hF);
                bus(1'b1, ADDR_PHASE, 16'(rnd()), 4'hF);
                pwm_chk();
            end
        end
        bus(1'b1, ADDR_OUTCTL, 16'h0400, 4'hF);
        rd(ADDR_OUTCTL);
        bus(1'b1, ADDR_DUTY, 16'd4, 4'hF);
        bus(1'b1, ADDR_PHASE, 16'd9, 4'hF);
        bus(1'b1, ADDR_GENCTL, 16'h0201, 4'hF);
        repeat (25) @(posedge mclk);
        hc = 0;
        repeat (20) begin
            @(negedge mclk);
            hc += int'(high_side_output);
        end
        chk_reg("local period high count", 32'((20 / (9 + 1)) * 4), 32'(hc));
        bus(1'b1, ADDR_GENCTL, 16'h0001, 4'hF);
        bus(1'b1, ADDR_DUTY, 16'hFFFF, 4'hF);
        bus(1'b1, ADDR_PHASE, 16'h0000, 4'hF);
        @(posedge mclk);
        master_count <= 16'h0000;
        foreach (codes[i]) begin
            pol = rs[3];
            lim = 9'(rnd());
            p = lpos(codes[i]);
            sel = (p >= 0) ? lim[p] : 1'b0;
            bus(1'b1, ADDR_FLCTL, {1'b0, codes[i], pol, 1'b1, 8'h00}, 4'hF);
            @(posedge mclk);
            limit_in <= lim;
            repeat (4) @(posedge mclk);
            bus(1'b0, ADDR_STATUS, 16'h0000, 4'hF);
            chk_pin("limit active", sel ^ pol, q[18]);
            @(negedge mclk);
            chk_pin("high under limit", !(sel ^ pol), high_side_output);
        end
        bus(1'b1, ADDR_FLCTL, 16'h0200, 4'hF);
        repeat (4) @(posedge mclk);
        bus(1'b0, ADDR_STATUS, 16'h0000, 4'hF);
        chk_pin("limit disabled", 1'b0, q[18]);
        // second reset with the fuse open: output control must take a plain write
        write_lock_fuse <= 1'b0;
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        foreach (m_reg[i]) m_reg[i] = 16'h0000;
        m_reg[2] = 16'h00F8;
        k1 = 1'b0;
        unl = 1'b1;
        rd(ADDR_FLCTL);
        bus(1'b1, ADDR_OUTCTL, 16'h0800, 4'hF);
        rd(ADDR_OUTCTL);
        stop_test();
    end
endmodule : pwm_duty_phase_current_limit_tb_top
`default_nettype wire
